// ===== verilog/i2cm_pkg.sv
// Constants, types and register map of the I2C bus master
//
// Overview of operation
// - Period setting one or more: bus clock is system clock / 8 / (setting+1).
// - Period setting zero: bus clock is system clock / 12, the fastest rate.
// - Multi-master: arbitrate on data and synchronise the shared bus clock.
// - Address the 7-bit target; direction bit one receives, zero sends.
// - Data buffer write loads the next byte sent, most significant bit first.
// - Data buffer read returns the byte captured by the latest receive.
// - Writing the clear bit resets the sequencer; the bit then clears itself.
// - With filter enabled, pulses under 50 ns on clock and data are ignored.
// - Busy shows while a byte shifts; other status is then not valid.
// - Idle status shows while the sequencer is idle and no transmit or receive mode is held.
// - Bus-occupied sets on a START and clears on a STOP seen on the bus.
// - Error summary sets on address nack, data nack or lost arbitration.
// - Address-not-acknowledged flag sets when the address got no acknowledge.
// - Data-not-acknowledged flag sets when a sent byte got no acknowledge.
// - Arbitration-lost flag sets when another master wins the bus.
// - A completion pulse marks each finished or aborted operation.
// - Ack bit one acknowledges received bytes; software clears it for the last.
// - Idle: START+RUN sends or receives, optional STOP; one combination illegal.
// - Transmitter: RUN sends, STOP stops, START repeats then sends or receives.
// - Receiver: RUN receives per ack bit, STOP stops, START repeats start.
// - Every combination not listed for the current mode is ignored.
// - Enabled timeout flags after (setting+1)*16*(period+1) clock cycles; clear resets it.
package i2cm_pkg;

  localparam logic [7:0] IDX_TARGET  = 8'hF4;
  localparam logic [7:0] IDX_CONTROL = 8'hF5;
  localparam logic [7:0] IDX_DATA    = 8'hF6;
  localparam logic [7:0] IDX_PERIOD  = 8'hF7;
  localparam logic [7:0] IDX_TIMEOUT = 8'hC3;
  localparam logic [7:0] RESET_BYTE  = 8'h00;

  // Control write bits and the timeout enable bit
  localparam int CB_RUN   = 0;
  localparam int CB_START = 1;
  localparam int CB_STOP  = 2;
  localparam int CB_ACK   = 3;
  localparam int CB_HS    = 4;
  localparam int CB_FILT  = 6;
  localparam int CB_CLEAR = 7;
  localparam int TO_EN    = 7;

  // Timing
  localparam int CLK_MHZ      = 20;
  localparam int FILT_NS      = 50;
  localparam int FILT_CYC     = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FAST_DIV     = 12;
  localparam int BASE_DIV     = 8;
  localparam logic [9:0] QTR_FAST = 10'(FAST_DIV / 4);

  typedef enum logic [2:0] {
    SQ_IDLE  = 3'b000,
    SQ_START = 3'b001,
    SQ_ADDR  = 3'b011,
    SQ_DATA  = 3'b010,
    SQ_STOP  = 3'b110
  } i2cm_seq_e;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_TX   = 2'b01,
    MODE_RX   = 2'b11
  } i2cm_mode_e;

  typedef struct packed {
    logic ok;
    logic start;
    logic xfer;
    logic rx;
    logic stop;
    logic ack;
  } i2cm_cmd_s;

endpackage

// ===== verilog/i2cm_top.sv
`timescale 1ns/100ps
// I2C bus master with classic Wishbone register access
module i2cm_top
  import i2cm_pkg::*;
#(
  parameter int ADR_W = 10
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  input  wire logic             scl_i,
  output logic                  scl_o,
  output logic                  scl_oe_n_o,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_n_o,
  output logic                  op_done_o
);

  function automatic i2cm_cmd_s dec_cmd(input i2cm_mode_e m,
                                        input logic [7:0] c,
                                        input logic       rs);
    i2cm_cmd_s r;
    r       = '0;
    r.ack   = c[CB_ACK];
    r.stop  = c[CB_STOP];
    if (c[CB_HS]) begin
      r.ok = 1'b0;
    end else if (c[CB_START] && c[CB_RUN]) begin
      r.ok    = ~(rs & c[CB_ACK] & c[CB_STOP]);
      r.start = 1'b1;
      r.xfer  = 1'b1;
      r.rx    = rs;
    end else if (m != MODE_IDLE && !c[CB_START]) begin
      r.rx = (m == MODE_RX);
      if (c[CB_RUN]) begin
        r.ok   = ~(r.rx & c[CB_ACK] & c[CB_STOP]);
        r.xfer = 1'b1;
      end else if (c[CB_STOP]) begin
        r.ok = 1'b1;
      end
    end
    return r;
  endfunction

  // Ack bit goes out low to acknowledge, released for nack
  function automatic logic [8:0] data_load(input logic       rx,
                                           input logic       ack,
                                           input logic [7:0] tx);
    return rx ? {8'hFF, ~ack} : {tx, 1'b1};
  endfunction

  // When enabled, a change is accepted only once it has outlasted the filter window
  function automatic logic [2:0] filt_step(input logic       en,
                                           input logic       raw,
                                           input logic       cur,
                                           input logic [1:0] cnt);
    if (!en) begin
      return {raw, 2'b00};
    end else if (raw == cur) begin
      return {cur, 2'b00};
    end else if (cnt >= 2'(FILT_CYC)) begin
      return {raw, 2'b00};
    end
    return {cur, 2'(cnt + 2'd1)};
  endfunction

  logic             ack_reg;
  logic [31:0]      dat_reg;
  logic [7:0]       rd_byte;
  logic [7:0]       tgt_reg;
  logic [7:0]       tx_data_reg;
  logic [7:0]       rx_data_reg;
  logic [7:0]       period_reg;
  logic [6:0]       to_set_reg;
  logic             to_en_reg;
  logic             to_flag_reg;
  logic             filt_en_reg;
  logic             clr_pend_reg;
  logic [1:0]       scl_sync_reg;
  logic [1:0]       sda_sync_reg;
  logic             scl_f_reg;
  logic             sda_f_reg;
  logic [1:0]       scl_cnt_reg;
  logic [1:0]       sda_cnt_reg;
  logic             sda_prev_reg;
  logic             bus_occ_reg;
  i2cm_seq_e        seq_reg;
  i2cm_mode_e       mode_reg;
  i2cm_cmd_s        cmd_reg;
  logic [1:0]       q_reg;
  logic [9:0]       qcnt_reg;
  logic [3:0]       bit_reg;
  logic [8:0]       sh_reg;
  logic [20:0]      to_cnt_reg;
  logic             arbitration_lost_reg;
  logic             addr_not_acked_reg;
  logic             data_not_acked_reg;
  logic             busy_d_reg;
  logic             done_reg;
  logic             scl_low_reg;
  logic             sda_low_reg;
  logic             scl_low_next;
  logic             sda_low_next;

  // Register bus decode
  wire              bus_req  = cyc_i & stb_i;
  wire              bus_new  = bus_req & ~ack_reg;
  wire [7:0]        reg_idx  = adr_i[9:2];
  wire              wr_lane  = bus_new & we_i & sel_i[0];
  wire              hit_tgt  = (reg_idx == IDX_TARGET);
  wire              hit_ctl  = (reg_idx == IDX_CONTROL);
  wire              hit_buf  = (reg_idx == IDX_DATA);
  wire              hit_per  = (reg_idx == IDX_PERIOD);
  wire              hit_to   = (reg_idx == IDX_TIMEOUT);
  wire              wr_ctl   = wr_lane & hit_ctl;
  wire [7:0]        wr_byte  = dat_i[7:0];

  // Sequencer status and commands
  wire              busy_st  = (seq_reg != SQ_IDLE);
  wire              idle_st  = (mode_reg == MODE_IDLE) & ~busy_st;
  wire              err_st   = arbitration_lost_reg | addr_not_acked_reg | data_not_acked_reg;
  wire i2cm_cmd_s   cmd_dec  = dec_cmd(mode_reg, wr_byte, tgt_reg[0]);
  wire              cmd_try  = wr_ctl & ~wr_byte[CB_CLEAR] & ~busy_st
                               & ~clr_pend_reg & cmd_dec.ok;
  wire              blocked  = cmd_try & cmd_dec.start
                               & (mode_reg == MODE_IDLE) & bus_occ_reg;
  wire              launch   = cmd_try & ~blocked;
  wire i2cm_mode_e  hold_md  = cmd_reg.rx ? MODE_RX : MODE_TX;

  // Bus clock timing
  wire [9:0]        qtr_len  = (period_reg == 8'h00) ? QTR_FAST
                               : {1'b0, period_reg, 1'b0} + 10'd2;
  wire              in_byte  = (seq_reg == SQ_ADDR) | (seq_reg == SQ_DATA);
  wire              wait_hi  = ((seq_reg == SQ_START || seq_reg == SQ_STOP)
                               && q_reg == 2'd1)
                               || (in_byte && q_reg == 2'd2);
  // Clock stretching by a slave or a slower master holds the quarter
  wire              stall    = wait_hi & ~scl_f_reg;
  wire              early    = in_byte & (q_reg == 2'd3) & ~scl_f_reg;
  wire              qtick    = busy_st & ~stall
                               & ((qcnt_reg == qtr_len - 10'd1) | early);
  wire              bit_end  = qtick & in_byte & (q_reg == 2'd3);
  wire              byte_end = bit_end & (bit_reg == 4'd8);
  wire              rx_phase = (seq_reg == SQ_DATA) & cmd_reg.rx;
  wire              arb_chk  = (bit_reg == 4'd8) ? rx_phase : ~rx_phase;
  wire              arb_lose = bit_end & arb_chk & sh_reg[8] & ~sda_f_reg;

  // Timeout while the bus clock is held low by someone else
  wire [7:0]        to_n     = {1'b0, to_set_reg} + 8'd1;
  wire [11:0]       bit_len  = {({1'b0, period_reg} + 9'd1), 3'b000};
  wire [20:0]       to_lim   = 21'({to_n, 1'b0} * bit_len);
  wire              to_hit   = to_en_reg & stall
                               & (to_cnt_reg == to_lim - 21'd1);

  wire [2:0]        scl_nx   = filt_step(filt_en_reg, scl_sync_reg[1],
                                         scl_f_reg, scl_cnt_reg);
  wire [2:0]        sda_nx   = filt_step(filt_en_reg, sda_sync_reg[1],
                                         sda_f_reg, sda_cnt_reg);
  wire              start_det = scl_f_reg & sda_prev_reg & ~sda_f_reg;
  wire              stop_det  = scl_f_reg & ~sda_prev_reg & sda_f_reg;

  assign ack_o      = ack_reg;
  assign dat_o      = dat_reg;
  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign scl_oe_n_o = ~scl_low_reg;
  assign sda_oe_n_o = ~sda_low_reg;
  assign op_done_o  = done_reg;

  always_comb begin
    if (hit_tgt) begin
      rd_byte = tgt_reg;
    end else if (hit_ctl) begin
      rd_byte = {clr_pend_reg, bus_occ_reg, idle_st, arbitration_lost_reg,
                 data_not_acked_reg, addr_not_acked_reg, err_st, busy_st};
    end else if (hit_buf) begin
      rd_byte = rx_data_reg;
    end else if (hit_per) begin
      rd_byte = period_reg;
    end else if (hit_to) begin
      rd_byte = {to_flag_reg, to_set_reg};
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Line drive for the current quarter of a start, bit or stop
  always_comb begin
    scl_low_next = (mode_reg != MODE_IDLE);
    sda_low_next = (mode_reg != MODE_IDLE);
    case (seq_reg)
      SQ_START: begin
        scl_low_next = (q_reg == 2'd0) & (mode_reg != MODE_IDLE);
        sda_low_next = q_reg[1];
      end
      SQ_ADDR, SQ_DATA: begin
        scl_low_next = ~q_reg[1];
        sda_low_next = ~sh_reg[8];
      end
      SQ_STOP: begin
        scl_low_next = (q_reg == 2'd0);
        sda_low_next = ~q_reg[1];
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_new;
      if (bus_new) begin
        dat_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tgt_reg      <= RESET_BYTE;
      tx_data_reg  <= RESET_BYTE;
      period_reg   <= RESET_BYTE;
      to_set_reg   <= 7'h00;
      to_en_reg    <= 1'b0;
      filt_en_reg  <= 1'b0;
      clr_pend_reg <= 1'b0;
    end else begin
      clr_pend_reg <= wr_ctl & wr_byte[CB_CLEAR];
      if (wr_lane && hit_tgt) begin
        tgt_reg <= wr_byte;
      end
      if (wr_lane && hit_buf) begin
        tx_data_reg <= wr_byte;
      end
      if (wr_lane && hit_per) begin
        period_reg <= wr_byte;
      end
      if (wr_lane && hit_to) begin
        to_en_reg  <= wr_byte[TO_EN];
        to_set_reg <= wr_byte[6:0];
      end
      if (wr_ctl) begin
        filt_en_reg <= wr_byte[CB_FILT];
      end
    end
  end

  // Pins cross into this clock through two flops before any use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_f_reg    <= 1'b1;
      sda_f_reg    <= 1'b1;
      scl_cnt_reg  <= 2'b00;
      sda_cnt_reg  <= 2'b00;
      sda_prev_reg <= 1'b1;
      bus_occ_reg  <= 1'b0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      {scl_f_reg, scl_cnt_reg} <= scl_nx;
      {sda_f_reg, sda_cnt_reg} <= sda_nx;
      sda_prev_reg <= sda_f_reg;
      if (start_det) begin
        bus_occ_reg <= 1'b1;
      end else if (stop_det) begin
        bus_occ_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      busy_d_reg  <= 1'b0;
      done_reg    <= 1'b0;
      qcnt_reg    <= 10'h000;
      to_cnt_reg  <= 21'h00_0000;
    end else begin
      scl_low_reg <= scl_low_next & ~clr_pend_reg;
      sda_low_reg <= sda_low_next & ~clr_pend_reg;
      busy_d_reg  <= busy_st;
      done_reg    <= (busy_d_reg & ~busy_st) | blocked;
      qcnt_reg    <= (!busy_st || qtick) ? 10'h000
                     : (stall ? qcnt_reg : qcnt_reg + 10'd1);
      to_cnt_reg  <= stall ? to_cnt_reg + 21'd1 : 21'h00_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_pend_reg) begin
      seq_reg      <= SQ_IDLE;
      mode_reg     <= MODE_IDLE;
      cmd_reg      <= '0;
      q_reg        <= 2'd0;
      bit_reg      <= 4'd0;
      sh_reg       <= 9'h1FF;
      arbitration_lost_reg  <= 1'b0;
      addr_not_acked_reg <= 1'b0;
      data_not_acked_reg <= 1'b0;
      to_flag_reg  <= 1'b0;
      rx_data_reg  <= RESET_BYTE;
    end else if (blocked) begin
      arbitration_lost_reg  <= 1'b1;
    end else if (launch) begin
      cmd_reg      <= cmd_dec;
      arbitration_lost_reg  <= 1'b0;
      addr_not_acked_reg <= 1'b0;
      data_not_acked_reg <= 1'b0;
      q_reg        <= 2'd0;
      bit_reg      <= 4'd0;
      sh_reg       <= data_load(cmd_dec.rx, cmd_dec.ack, tx_data_reg);
      seq_reg      <= cmd_dec.start ? SQ_START
                      : (cmd_dec.xfer ? SQ_DATA : SQ_STOP);
    end else if (to_hit) begin
      to_flag_reg  <= 1'b1;
      seq_reg      <= SQ_IDLE;
      mode_reg     <= MODE_IDLE;
    end else if (arb_lose) begin
      arbitration_lost_reg  <= 1'b1;
      seq_reg      <= SQ_IDLE;
      mode_reg     <= MODE_IDLE;
    end else if (qtick) begin
      q_reg <= q_reg + 2'd1;
      if (q_reg == 2'd3) begin
        case (seq_reg)
          SQ_START: begin
            seq_reg <= SQ_ADDR;
            bit_reg <= 4'd0;
            sh_reg  <= {tgt_reg, 1'b1};
          end
          SQ_ADDR, SQ_DATA: begin
            sh_reg  <= {sh_reg[7:0], sda_f_reg};
            bit_reg <= bit_reg + 4'd1;
            if (byte_end) begin
              bit_reg <= 4'd0;
              if (seq_reg == SQ_ADDR && !sda_f_reg) begin
                seq_reg <= SQ_DATA;
                sh_reg  <= data_load(cmd_reg.rx, cmd_reg.ack, tx_data_reg);
              end else begin
                seq_reg  <= cmd_reg.stop ? SQ_STOP : SQ_IDLE;
                mode_reg <= hold_md;
              end
              if (seq_reg == SQ_ADDR && sda_f_reg) begin
                addr_not_acked_reg <= 1'b1;
              end
              if (seq_reg == SQ_DATA && !cmd_reg.rx && sda_f_reg) begin
                data_not_acked_reg <= 1'b1;
              end
              if (rx_phase) begin
                rx_data_reg <= sh_reg[7:0];
              end
            end
          end
          SQ_STOP: begin
            seq_reg  <= SQ_IDLE;
            mode_reg <= MODE_IDLE;
          end
          default: begin
          end
        endcase
      end
    end
  end

  sequence s_q0_start;
    busy_st && !stall && q_reg == 2'd0 && qcnt_reg == 10'h000;
  endsequence

  sequence s_clear_write;
    wr_ctl && wr_byte[CB_CLEAR];
  endsequence

  property p_fast_rate;
    @(posedge clk_i) disable iff (rst_i)
      s_q0_start and period_reg == 8'h00 |-> !qtick ##1 !qtick ##1 qtick;
  endproperty
  a_fast_rate: assert property (p_fast_rate)
    else $error("fast quarter is not three cycles");

  property p_div_rate;
    @(posedge clk_i) disable iff (rst_i)
      s_q0_start and period_reg == 8'h01 |-> (!qtick)[*3] ##1 qtick;
  endproperty
  a_div_rate: assert property (p_div_rate)
    else $error("quarter length wrong for period one");

  property p_clear;
    @(posedge clk_i) disable iff (rst_i)
      s_clear_write |=> clr_pend_reg ##1 (!clr_pend_reg && idle_st);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not reset the sequencer");

  property p_launch_busy;
    @(posedge clk_i) disable iff (rst_i)
      launch |=> busy_st && !err_st;
  endproperty
  a_launch_busy: assert property (p_launch_busy)
    else $error("launch did not set busy");

  property p_glitch;
    @(posedge clk_i) disable iff (rst_i)
      (filt_en_reg && scl_sync_reg[1] != scl_f_reg && scl_cnt_reg == 2'b00)
      ##1 (filt_en_reg && scl_sync_reg[1] == scl_f_reg) |=> $stable(scl_f_reg);
  endproperty
  a_glitch: assert property (p_glitch)
    else $error("short pulse passed the filter");

  property p_bus_occ;
    @(posedge clk_i) disable iff (rst_i)
      (start_det |=> bus_occ_reg) and (stop_det |=> !bus_occ_reg);
  endproperty
  a_bus_occ: assert property (p_bus_occ)
    else $error("bus occupied flag wrong");

  property p_addr_nack;
    @(posedge clk_i) disable iff (rst_i || clr_pend_reg)
      byte_end && seq_reg == SQ_ADDR && sda_f_reg && !arb_lose && !to_hit
      |=> addr_not_acked_reg && err_st;
  endproperty
  a_addr_nack: assert property (p_addr_nack)
    else $error("address nack not flagged");

  property p_done;
    @(posedge clk_i) disable iff (rst_i)
      busy_st ##1 !busy_st |=> op_done_o ##1 !op_done_o;
  endproperty
  a_done: assert property (p_done)
    else $error("completion pulse missing");

  property p_rx_capture;
    @(posedge clk_i) disable iff (rst_i || clr_pend_reg)
      byte_end && rx_phase && !arb_lose && !to_hit
      |=> rx_data_reg == $past(sh_reg[7:0]);
  endproperty
  a_rx_capture: assert property (p_rx_capture)
    else $error("received byte not captured");

  property p_timeout;
    @(posedge clk_i) disable iff (rst_i || clr_pend_reg)
      to_hit |=> to_flag_reg && !busy_st ##1 op_done_o;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout not flagged");

  // Status read during a byte must report busy and not idle
  property p_busy_shift;
    @(posedge clk_i) disable iff (rst_i)
      in_byte && bus_new && hit_ctl && !we_i |=> dat_o[0] && !dat_o[5];
  endproperty
  a_busy_shift: assert property (p_busy_shift)
    else $error("busy low while shifting");

endmodule

// ===== bench/i2cm_slave_model.sv
// Behavioural I2C slave facing the bus master
`timescale 1ns/100ps
module i2cm_slave_model #(
  parameter logic [6:0] ADDR  = 7'h2A,
  parameter logic [7:0] RDATA = 8'hA5
) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            pull_o,
  output logic [7:0]      got_o
);
  int         bitn = 0;
  logic [7:0] sh   = 8'h00;
  logic       aph  = 1'b0;
  logic       sel  = 1'b0;
  logic       rd   = 1'b0;
  logic       mack = 1'b0;
  initial pull_o = 1'b0;
  initial got_o = 8'h00;
  // START or repeated START while clock high
  always @(negedge sda_i) if (scl_i) begin
    bitn = 0;
    aph = 1'b1;
    sel = 1'b0;
  end
  always @(posedge scl_i) begin
    bitn = bitn + 1;
    if (bitn < 9)
      sh = {sh[6:0], sda_i};
    else if (!pull_o)
      mack = !sda_i;
  end
  // Data changes only while clock low; no answer once master nacks
  always @(negedge scl_i) begin
    pull_o = 1'b0;
    if (bitn == 8 && aph) begin
      sel = (sh[7:1] == ADDR);
      rd = sh[0];
      aph = 1'b0;
      mack = 1'b1;
      pull_o = sel;
    end else if (bitn == 8 && sel && !rd) begin
      got_o = sh;
      pull_o = 1'b1;
    end else if (bitn >= 9) begin
      bitn = 0;
    end
    if (sel && rd && mack && bitn < 8 && !aph)
      pull_o = !RDATA[7-bitn];
  end
endmodule

// ===== bench/i2c_master_controller_bench.sv
// Self-checking bench for the I2C bus master
`timescale 1ns/100ps
module i2c_master_controller_bench;
  import i2cm_pkg::*;
  localparam logic [6:0] SADR  = 7'h2A;
  localparam logic [7:0] RBYTE = 8'hA5;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [9:0]  adr_i = 10'h000;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        scl_oe_n_o;
  logic        sda_oe_n_o;
  logic        op_done_o;
  logic        pull;
  logic [7:0]  got;
  logic        scl_hold = 1'b0;
  logic        sda_hold = 1'b0;
  wire         scl_w = scl_oe_n_o & ~scl_hold;
  wire         sda_w = sda_oe_n_o & ~pull & ~sda_hold;
  int          fails = 0;
  int          n_tests = 0;
  int          dones = 0;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (op_done_o === 1'b1) dones <= dones + 1;
  i2cm_top #(.ADR_W(10)) i2cm_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .scl_i(scl_w), .scl_o(),
    .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(),
    .sda_oe_n_o(sda_oe_n_o), .op_done_o(op_done_o));
  i2cm_slave_model #(.ADDR(SADR), .RDATA(RBYTE)) i2cm_slave_model_inst (
    .scl_i(scl_w), .sda_i(sda_w), .pull_o(pull), .got_o(got));
  task automatic results;
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] i, d,
                    output logic [7:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'h1;
    adr_i <= {i, 2'b00};
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (k >= 50) begin
      fails++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] i, d);
    logic [7:0] q;
    wb(1'b1, i, d, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] i, e);
    logic [7:0] q;
    wb(1'b0, i, 8'h00, q);
    chk(nm, e, q);
  endtask
  // Launch a command, check busy right after it, wait for completion
  task automatic run(input logic [7:0] cmd, input logic bz);
    logic [7:0] q;
    int d0;
    int k;
    d0 = dones;
    k = 0;
    wr(IDX_CONTROL, cmd);
    wb(1'b0, IDX_CONTROL, 8'h00, q);
    chk("busy", {7'h0, bz}, {7'h0, q[0]});
    while (dones == d0 && k < 4000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 4000) begin
      fails++;
      results();
    end
  endtask
  task automatic t_regs;
    rdc("target", IDX_TARGET, 8'h00);
    rdc("data", IDX_DATA, 8'h00);
    rdc("period", IDX_PERIOD, 8'h00);
    wr(IDX_TARGET, 8'h55);
    wr(IDX_PERIOD, 8'h03);
    rdc("target", IDX_TARGET, 8'h55);
    rdc("period", IDX_PERIOD, 8'h03);
    rdc("unmapped", 8'h40, 8'h00);
    wr(IDX_PERIOD, 8'h00);
  endtask
  task automatic t_tx;
    wr(IDX_TARGET, {SADR, 1'b0});
    run(8'h03, 1'b1);
    rdc("tx mode", IDX_CONTROL, 8'h40);
    wr(IDX_DATA, 8'h5A);
    wr(IDX_PERIOD, 8'h01);
    run(8'h01, 1'b1);
    wr(IDX_PERIOD, 8'h00);
    chk("sent", 8'h5A, got);
    run(8'h04, 1'b1);
    rdc("stopped", IDX_CONTROL, 8'h20);
  endtask
  task automatic t_read;
    wr(IDX_TARGET, {SADR, 1'b1});
    wr(IDX_CONTROL, 8'h40);
    @(posedge clk_i);
    scl_hold <= 1'b1;
    @(posedge clk_i);
    scl_hold <= 1'b0;
    rdc("glitch", IDX_CONTROL, 8'h20);
    run(8'h47, 1'b1);
    rdc("rx status", IDX_CONTROL, 8'h20);
    rdc("rx byte", IDX_DATA, RBYTE);
    run(8'h4B, 1'b1);
    rdc("rx mode", IDX_CONTROL, 8'h40);
    run(8'h45, 1'b1);
    rdc("burst end", IDX_CONTROL, 8'h20);
    rdc("rx byte 2", IDX_DATA, RBYTE);
  endtask
  task automatic t_nack;
    wr(IDX_TARGET, {7'h11, 1'b0});
    run(8'h07, 1'b1);
    rdc("nack", IDX_CONTROL, 8'h26);
  endtask
  task automatic t_illegal;
    int d0;
    d0 = dones;
    wr(IDX_TARGET, {SADR, 1'b1});
    wr(IDX_CONTROL, 8'h0F);
    rdc("illegal", IDX_CONTROL, 8'h26);
    repeat (40) @(posedge clk_i);
    chk("no done", 8'(d0), 8'(dones));
    chk("scl idle", 8'h01, {7'h0, scl_w});
  endtask
  // Clear lands before the START reaches the bus
  task automatic t_clear;
    logic [7:0] q;
    wr(IDX_TARGET, {SADR, 1'b0});
    wr(IDX_CONTROL, 8'h03);
    run(8'h80, 1'b0);
    wb(1'b0, IDX_CONTROL, 8'h00, q);
    chk("clear", 8'h20, q & 8'hA1);
  endtask
  // Another master holds the bus, then the clock is held low until the timeout fires
  task automatic t_abort;
    @(posedge clk_i);
    sda_hold <= 1'b1;
    repeat (8) @(posedge clk_i);
    run(8'h03, 1'b0);
    rdc("blocked", IDX_CONTROL, 8'h72);
    @(posedge clk_i);
    sda_hold <= 1'b0;
    repeat (8) @(posedge clk_i);
    wr(IDX_TIMEOUT, 8'h80);
    scl_hold <= 1'b1;
    run(8'h03, 1'b1);
    scl_hold <= 1'b0;
    rdc("to flag", IDX_TIMEOUT, 8'h80);
    rdc("to status", IDX_CONTROL, 8'h20);
    wr(IDX_CONTROL, 8'h80);
    rdc("to clear", IDX_TIMEOUT, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_tx();
    t_read();
    t_nack();
    t_illegal();
    t_clear();
    t_abort();
    results();
  end
endmodule
